// *** design/pss_cfg.svh ***
// Constants of the preset speed selector: offsets, fields, reset values, timing.
// Function
// - Motor overload trip after programmed 10-2400 s.
// - Drive overload protection fixed, never disabled.
// - Drive trips sooner above 120% or below 0.1Hz.
// - Fifteen presets chosen by contact inputs.
// - Preset frequency clamped between lower/upper limits.
// - Run source panel by default, selectable.
// - All contacts open: panel or analog used.
// - Preset always beats other speed commands.
// - Inputs default to functions 10, 12, 14, 16; third 14.
// - Mode disabled: preset governs frequency only.
// - Mode enabled: per-preset direction, sets applied.
// - Mode enabled, preset active: direction from word, terminals ignored.
// - Weight 2, 4 select acc/dec switching 1, 2.
// - Weights summed, each decoded independently.
// - Both switching bits select set four.
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_CLK_HZ 125000000
`define PSS_TICK_PERIOD_S 1
`define PSS_TICKS_PER_S (`PSS_TICK_PERIOD_S * `PSS_CLK_HZ)
`define PSS_REG_CTRL 8'h00
`define PSS_REG_LL 8'h04
`define PSS_REG_UL 8'h08
`define PSS_REG_OLTIME 8'h0C
`define PSS_REG_STATUS 8'h10
`define PSS_REG_MASK 8'h14
`define PSS_REG_STATE 8'h18
`define PSS_REG_INFUNC 8'h1C
`define PSS_REG_FREQ_PAGE 2'h1
`define PSS_REG_WORD_PAGE 2'h2
`define PSS_CTRL_MODE_BIT 0
`define PSS_CTRL_SRC_LSB 1
`define PSS_CTRL_TRIPCLR_BIT 4
`define PSS_SRC_TERMINAL 3'h0
`define PSS_SRC_PANEL 3'h1
`define PSS_SRC_SERIAL 3'h2
`define PSS_SRC_RS485 3'h3
`define PSS_SRC_CASSETTE 3'h4
`define PSS_RST_SRC 3'h1
`define PSS_RST_LL 16'h0000
`define PSS_RST_UL 16'h0258
`define PSS_RST_OLTIME 12'h12C
`define PSS_OLTIME_MIN 12'h00A
`define PSS_OLTIME_MAX 12'h960
`define PSS_RST_FREQ 16'h0000
`define PSS_RST_WORD 7'h00
`define PSS_RST_FUNC0 8'h0A
`define PSS_RST_FUNC1 8'h0C
`define PSS_RST_FUNC2 8'h0E
`define PSS_RST_FUNC3 8'h10
`define PSS_W_REVERSE 0
`define PSS_W_ACC1 1
`define PSS_W_ACC2 2
`define PSS_W_VF1 3
`define PSS_W_VF2 4
`define PSS_W_TQ1 5
`define PSS_W_TQ2 6
`define PSS_MOT_OL_PCT 8'h96
`define PSS_DRV_OL_PCT 8'h6E
`define PSS_DRV_FAST_PCT 8'h78
`define PSS_DRV_FAST_FREQ 16'h0001
`define PSS_DRV_LIMIT_S 12'h03C
`define PSS_DRV_FAST_LIMIT_S 12'h00A
`define PSS_EV_MOT 0
`define PSS_EV_DRV 1
`define PSS_EV_PRESET 2
`endif

// *** design/pss_pkg.sv ***
// Types shared by the preset speed selector.
package pss_pkg;
    typedef struct packed {
        logic [31:0] rdata;
        logic mode_en;
        logic [2:0] src;
        logic [15:0] ll;
        logic [15:0] ul;
        logic [11:0] ol_lim;
        logic [2:0] sts;
        logic [2:0] msk;
        logic [3:0][7:0] fsel;
        logic [15:1][15:0] pfreq;
        logic [15:1][6:0] pword;
        logic [26:0] pre;
        logic tick;
        logic [11:0] mot_s;
        logic [11:0] drv_s;
        logic mot_trip;
        logic drv_trip;
        logic [3:0] idx;
        logic [15:0] freq;
        logic preset_act;
        logic rev;
        logic [1:0] acc;
        logic [1:0] vf;
        logic [1:0] tq;
        logic run;
    } pss_state_t;
endpackage : pss_pkg

// *** design/pss_selector.sv ***
// Preset speed selector with overload trip timing and register port.
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"
module pss_selector #(
    parameter int TICKS_PER_S = `PSS_TICKS_PER_S
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic preset_select_in0,
    input wire logic preset_select_in1,
    input wire logic preset_select_in2,
    input wire logic preset_select_in3,
    input wire logic [15:0] panel_freq,
    input wire logic panel_freq_valid,
    input wire logic [15:0] analog_freq,
    input wire logic analog_freq_valid,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic run_panel,
    input wire logic run_serial,
    input wire logic run_rs485,
    input wire logic run_cassette,
    input wire logic [7:0] motor_load_pct,
    input wire logic [7:0] drive_load_pct,
    input wire logic [15:0] out_freq,
    output logic [15:0] freq_cmd,
    output logic preset_active,
    output logic reverse,
    output logic [1:0] acc_set,
    output logic [1:0] vf_set,
    output logic [1:0] torque_set,
    output logic run_cmd,
    output logic motor_ol_trip,
    output logic drive_ol_trip,
    output logic irq
);
    import pss_pkg::*;

    pss_state_t q;
    pss_state_t d;
    logic [3:0] closed;
    logic [3:0] idx;
    logic [15:0] f;
    logic [6:0] w;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [11:0] drv_lim;
    logic [11:0] lim_w;
    logic run_term;

    // Two set bits map to set index: none 0, first 1, second 2, both 3.
    function automatic logic [1:0] set_of(input logic s1, input logic s2);
        set_of = {s2, s1};
    endfunction : set_of

    always_comb begin
        d = q;
        d.rdata = 32'h0000_0000;
        d.tick = 1'b0;
        ev = 3'h0;
        clr = 3'h0;
        lim_w = reg_wdata[11:0];
        if (q.pre == 27'(TICKS_PER_S - 1)) begin
            d.pre = 27'h0;
            d.tick = 1'b1;
        end else begin
            d.pre = q.pre + 27'h1;
        end
        // Register writes.
        if (reg_we) begin
            case (reg_addr)
                `PSS_REG_CTRL: begin
                    d.mode_en = reg_wdata[`PSS_CTRL_MODE_BIT];
                    d.src = reg_wdata[`PSS_CTRL_SRC_LSB +: 3];
                    if (reg_wdata[`PSS_CTRL_TRIPCLR_BIT]) begin
                        d.mot_trip = 1'b0;
                        d.drv_trip = 1'b0;
                        d.mot_s = 12'h000;
                        d.drv_s = 12'h000;
                    end
                end
                `PSS_REG_LL: d.ll = reg_wdata[15:0];
                `PSS_REG_UL: d.ul = reg_wdata[15:0];
                `PSS_REG_OLTIME: begin
                    if (reg_wdata[31:12] != 20'h0_0000 || lim_w > `PSS_OLTIME_MAX) begin
                        d.ol_lim = `PSS_OLTIME_MAX;
                    end else if (lim_w < `PSS_OLTIME_MIN) begin
                        d.ol_lim = `PSS_OLTIME_MIN;
                    end else begin
                        d.ol_lim = lim_w;
                    end
                end
                `PSS_REG_STATUS: clr = reg_wdata[2:0];
                `PSS_REG_MASK: d.msk = reg_wdata[2:0];
                `PSS_REG_INFUNC: d.fsel = reg_wdata;
                default: begin
                    if (reg_addr[7:6] == `PSS_REG_FREQ_PAGE && reg_addr[5:2] != 4'h0) begin
                        d.pfreq[reg_addr[5:2]] = reg_wdata[15:0];
                    end else if (reg_addr[7:6] == `PSS_REG_WORD_PAGE
                                 && reg_addr[5:2] != 4'h0) begin
                        d.pword[reg_addr[5:2]] = reg_wdata[6:0];
                    end
                end
            endcase
        end
        // Register reads, data valid in the next cycle.
        if (reg_re) begin
            case (reg_addr)
                `PSS_REG_CTRL: d.rdata = {28'h0, q.src, q.mode_en};
                `PSS_REG_LL: d.rdata = {16'h0, q.ll};
                `PSS_REG_UL: d.rdata = {16'h0, q.ul};
                `PSS_REG_OLTIME: d.rdata = {20'h0, q.ol_lim};
                `PSS_REG_STATUS: d.rdata = {29'h0, q.sts};
                `PSS_REG_MASK: d.rdata = {29'h0, q.msk};
                `PSS_REG_STATE: begin
                    d.rdata = {1'b0, q.drv_trip, q.mot_trip, q.run, q.tq, q.vf, q.acc,
                               q.rev, q.preset_act, q.idx, q.freq};
                end
                `PSS_REG_INFUNC: d.rdata = q.fsel;
                default: begin
                    if (reg_addr[7:6] == `PSS_REG_FREQ_PAGE && reg_addr[5:2] != 4'h0) begin
                        d.rdata = {16'h0, q.pfreq[reg_addr[5:2]]};
                    end else if (reg_addr[7:6] == `PSS_REG_WORD_PAGE
                                 && reg_addr[5:2] != 4'h0) begin
                        d.rdata = {25'h0, q.pword[reg_addr[5:2]]};
                    end
                end
            endcase
        end
        // Contact decode: an input counts only while its function is preset select.
        closed[0] = preset_select_in0 && q.fsel[0] == `PSS_RST_FUNC0;
        closed[1] = preset_select_in1 && q.fsel[1] == `PSS_RST_FUNC1;
        closed[2] = preset_select_in2 && q.fsel[2] == `PSS_RST_FUNC2;
        closed[3] = preset_select_in3 && q.fsel[3] == `PSS_RST_FUNC3;
        idx = closed;
        d.idx = idx;
        d.preset_act = idx != 4'h0;
        w = `PSS_RST_WORD;
        if (idx != 4'h0) begin
            f = q.pfreq[idx];
            w = q.pword[idx];
        end else if (panel_freq_valid) begin
            f = panel_freq;
        end else if (analog_freq_valid) begin
            f = analog_freq;
        end else begin
            f = 16'h0000;
        end
        if (idx != 4'h0 && f < q.ll) begin
            f = q.ll;
        end
        if (idx != 4'h0 && f > q.ul) begin
            f = q.ul;
        end
        d.freq = f;
        run_term = run_fwd || run_rev;
        case (q.src)
            `PSS_SRC_TERMINAL: d.run = run_term;
            `PSS_SRC_PANEL: d.run = run_panel;
            `PSS_SRC_SERIAL: d.run = run_serial;
            `PSS_SRC_RS485: d.run = run_rs485;
            `PSS_SRC_CASSETTE: d.run = run_cassette;
            default: d.run = run_panel;
        endcase
        if (q.mode_en && idx != 4'h0) begin
            d.rev = w[`PSS_W_REVERSE];
            d.acc = set_of(w[`PSS_W_ACC1], w[`PSS_W_ACC2]);
            d.vf = set_of(w[`PSS_W_VF1], w[`PSS_W_VF2]);
            d.tq = set_of(w[`PSS_W_TQ1], w[`PSS_W_TQ2]);
        end else begin
            d.rev = run_rev && !run_fwd;
            d.acc = 2'h0;
            d.vf = 2'h0;
            d.tq = 2'h0;
        end
        // Motor overload timer at 150 percent load.
        if (motor_load_pct >= `PSS_MOT_OL_PCT) begin
            if (q.tick && !q.mot_trip) begin
                d.mot_s = q.mot_s + 12'h001;
            end
            if (q.mot_s >= q.ol_lim && !q.mot_trip) begin
                d.mot_trip = 1'b1;
                ev[`PSS_EV_MOT] = 1'b1;
            end
        end else if (!q.mot_trip) begin
            d.mot_s = 12'h000;
        end
        // Drive overload timer, fixed and always active.
        if (drive_load_pct > `PSS_DRV_FAST_PCT || out_freq < `PSS_DRV_FAST_FREQ) begin
            drv_lim = `PSS_DRV_FAST_LIMIT_S;
        end else begin
            drv_lim = `PSS_DRV_LIMIT_S;
        end
        if (drive_load_pct >= `PSS_DRV_OL_PCT) begin
            if (q.tick && !q.drv_trip) begin
                d.drv_s = q.drv_s + 12'h001;
            end
            if (q.drv_s >= drv_lim && !q.drv_trip) begin
                d.drv_trip = 1'b1;
                ev[`PSS_EV_DRV] = 1'b1;
            end
        end else if (!q.drv_trip) begin
            d.drv_s = 12'h000;
        end
        ev[`PSS_EV_PRESET] = idx != q.idx;
        d.sts = (q.sts & ~clr) | ev;
        if (!resetn) begin
            d = '0;
            d.src = `PSS_RST_SRC;
            d.ll = `PSS_RST_LL;
            d.ul = `PSS_RST_UL;
            d.ol_lim = `PSS_RST_OLTIME;
            d.fsel = {`PSS_RST_FUNC3, `PSS_RST_FUNC2, `PSS_RST_FUNC1, `PSS_RST_FUNC0};
            d.pfreq = {15{`PSS_RST_FREQ}};
            d.pword = {15{`PSS_RST_WORD}};
        end
    end

    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    assign reg_rdata = q.rdata;
    assign freq_cmd = q.freq;
    assign preset_active = q.preset_act;
    assign reverse = q.rev;
    assign acc_set = q.acc;
    assign vf_set = q.vf;
    assign torque_set = q.tq;
    assign run_cmd = q.run;
    assign motor_ol_trip = q.mot_trip;
    assign drive_ol_trip = q.drv_trip;
    assign irq = |(q.sts & q.msk);
endmodule : pss_selector
`default_nettype wire

// *** testbench/pss_contacts.sv ***
// Contact bank that moves all preset selection contacts together.
`timescale 1ns/1ps
`default_nettype none
module pss_contacts (
    input wire logic ref_clk,
    input wire logic [3:0] sel,
    output logic preset_select_in0,
    output logic preset_select_in1,
    output logic preset_select_in2,
    output logic preset_select_in3
);
    always_ff @(posedge ref_clk) begin
        {preset_select_in3, preset_select_in2, preset_select_in1, preset_select_in0} <= sel;
    end
endmodule : pss_contacts
`default_nettype wire

// *** testbench/pss_selector_sva.sv ***
// Port checker of the preset speed selector.
`timescale 1ns/1ps
`default_nettype none
module pss_selector_sva #(
    parameter int TICKS_PER_S = 10
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [31:0] reg_rdata,
    input wire logic preset_select_in0,
    input wire logic preset_select_in1,
    input wire logic preset_select_in2,
    input wire logic preset_select_in3,
    input wire logic [15:0] panel_freq,
    input wire logic panel_freq_valid,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic [7:0] motor_load_pct,
    input wire logic [7:0] drive_load_pct,
    input wire logic [15:0] freq_cmd,
    input wire logic preset_active,
    input wire logic reverse,
    input wire logic [1:0] acc_set,
    input wire logic [1:0] vf_set,
    input wire logic [1:0] torque_set,
    input wire logic motor_ol_trip,
    input wire logic drive_ol_trip,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] psel;
    logic clr;
    assign psel = {preset_select_in3, preset_select_in2, preset_select_in1, preset_select_in0};
    assign clr = reg_we && reg_addr == 8'h00 && reg_wdata[4];
    logic func_dflt;
    // Set while every input keeps its preset select function; a_act checks only then.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            func_dflt <= 1'b1;
        end else if (reg_we && reg_addr == 8'h1C) begin
            func_dflt <= reg_wdata == 32'h100E0C0A;
        end
    end
    property p_rd_idle;
        !reg_re |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_none;
        resetn && psel == 4'h0 && panel_freq_valid |=> freq_cmd == $past(panel_freq)
            && !preset_active;
    endproperty
    a_none: assert property (p_none) else $error("panel speed not used");
    property p_act;
        func_dflt && psel != 4'h0 |=> preset_active;
    endproperty
    a_act: assert property (p_act) else $error("preset not active");
    property p_dir;
        psel == 4'h0 |=> reverse == $past(run_rev && !run_fwd) && acc_set == 2'h0
            && vf_set == 2'h0 && torque_set == 2'h0;
    endproperty
    a_dir: assert property (p_dir) else $error("sets not default");
    property p_mot_hold;
        motor_ol_trip && !clr |=> motor_ol_trip;
    endproperty
    a_mot_hold: assert property (p_mot_hold) else $error("motor trip lost");
    property p_drv_hold;
        drive_ol_trip && !clr |=> drive_ol_trip;
    endproperty
    a_drv_hold: assert property (p_drv_hold) else $error("drive trip lost");
    property p_mot_cause;
        $rose(motor_ol_trip) |-> $past(motor_load_pct) >= 8'h96;
    endproperty
    a_mot_cause: assert property (p_mot_cause) else $error("motor trip low load");
    property p_clr;
        clr |=> !motor_ol_trip && !drive_ol_trip;
    endproperty
    a_clr: assert property (p_clr) else $error("trip not cleared");
    c_act: cover property ($rose(preset_active));
    c_mot: cover property ($rose(motor_ol_trip));
    c_irq: cover property ($rose(irq));
endmodule : pss_selector_sva
bind pss_selector pss_selector_sva #(.TICKS_PER_S(TICKS_PER_S)) i_pss_selector_sva (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .preset_select_in0(preset_select_in0), .preset_select_in1(preset_select_in1),
    .preset_select_in2(preset_select_in2), .preset_select_in3(preset_select_in3),
    .panel_freq(panel_freq), .panel_freq_valid(panel_freq_valid), .run_fwd(run_fwd),
    .run_rev(run_rev), .motor_load_pct(motor_load_pct), .drive_load_pct(drive_load_pct),
    .freq_cmd(freq_cmd), .preset_active(preset_active), .reverse(reverse),
    .acc_set(acc_set), .vf_set(vf_set), .torque_set(torque_set),
    .motor_ol_trip(motor_ol_trip), .drive_ol_trip(drive_ol_trip), .irq(irq));
`default_nettype wire

// *** testbench/pss_selector_tb_top.sv ***
// Testbench of the preset speed selector.
`timescale 1ns/1ps
`default_nettype none
module pss_selector_tb_top;
    import pss_pkg::*;
    localparam int TPS = 10;
    logic ref_clk = 1'b0, resetn = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00, motor_load_pct = 8'h00, drive_load_pct = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] sel = 4'h0;
    logic preset_select_in0, preset_select_in1, preset_select_in2, preset_select_in3;
    logic [15:0] panel_freq = 16'h0309, analog_freq = 16'h00AB, out_freq = 16'h0064;
    logic panel_freq_valid = 1'b1, analog_freq_valid = 1'b1, run_fwd = 1'b1, run_rev = 1'b0;
    logic run_panel = 1'b0, run_serial = 1'b0, run_rs485 = 1'b0, run_cassette = 1'b0;
    logic [15:0] freq_cmd;
    logic preset_active, reverse, run_cmd, motor_ol_trip, drive_ol_trip, irq;
    logic [1:0] acc_set, vf_set, torque_set;
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h30, 8'h40};
    logic [31:0] rv [9] = '{32'h2, 32'h0, 32'h258, 32'h12C, 32'h0, 32'h0, 32'h100E0C0A, 32'h0,
        32'h0};
    logic [7:0] dl [3] = '{8'h73, 8'h82, 8'h73};
    int dlo [3] = '{55, 9, 9};
    int dhi [3] = '{65, 13, 13};
    int err_count = 0, check_count = 0;
    logic [15:0] f;
    logic [6:0] w;
    always #4 ref_clk = ~ref_clk;
    pss_contacts i_pss_contacts (.ref_clk(ref_clk), .sel(sel),
        .preset_select_in0(preset_select_in0), .preset_select_in1(preset_select_in1),
        .preset_select_in2(preset_select_in2), .preset_select_in3(preset_select_in3));
    pss_selector #(.TICKS_PER_S(TPS)) i_pss_selector (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .preset_select_in0(preset_select_in0),
        .preset_select_in1(preset_select_in1), .preset_select_in2(preset_select_in2),
        .preset_select_in3(preset_select_in3), .panel_freq(panel_freq),
        .panel_freq_valid(panel_freq_valid), .analog_freq(analog_freq),
        .analog_freq_valid(analog_freq_valid), .run_fwd(run_fwd), .run_rev(run_rev),
        .run_panel(run_panel), .run_serial(run_serial), .run_rs485(run_rs485),
        .run_cassette(run_cassette), .motor_load_pct(motor_load_pct),
        .drive_load_pct(drive_load_pct), .out_freq(out_freq), .freq_cmd(freq_cmd),
        .preset_active(preset_active), .reverse(reverse), .acc_set(acc_set),
        .vf_set(vf_set), .torque_set(torque_set), .run_cmd(run_cmd),
        .motor_ol_trip(motor_ol_trip), .drive_ol_trip(drive_ol_trip), .irq(irq));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic pick(input logic [3:0] s);
        @(posedge ref_clk);
        sel <= s;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : pick
    task automatic wt(input bit drv, input int lo, input int hi);
        int n;
        n = 0;
        while ((drv ? drive_ol_trip : motor_ol_trip) !== 1'b1 && n < hi * TPS) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(n >= lo * TPS && n < hi * TPS, 1);
    endtask : wt
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        wr(8'h0C, 32'h5);
        rd(8'h0C, 32'h00A);
        wr(8'h0C, 32'hBB8);
        rd(8'h0C, 32'h960);
        wr(8'h04, 32'h64);
        wr(8'h08, 32'h1F4);
        for (int i = 1; i < 16; i++) begin
            wr(8'h40 + 8'(4 * i), 32'(50 * i));
            wr(8'h80 + 8'(4 * i), 32'((i * 9) & 8'h7F));
        end
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 32'(2 + m));
            for (int i = 1; i < 16; i++) begin
                pick(4'(i));
                w = 7'((i * 9) & 8'h7F);
                f = (i < 2) ? 16'h64 : (i > 9) ? 16'h1F4 : 16'(50 * i);
                chk(freq_cmd, f);
                chk(preset_active, 1);
                chk({torque_set, vf_set, acc_set, reverse}, m ? w : 7'h0);
            end
        end
        pick(4'h0);
        chk(freq_cmd, 16'h0309);
        @(posedge ref_clk);
        panel_freq_valid <= 1'b0;
        run_panel <= 1'b1;
        pick(4'h0);
        chk(freq_cmd, 16'h00AB);
        chk(run_cmd, 1);
        wr(8'h00, 32'h6);
        pick(4'h0);
        chk(run_cmd, 0);
        @(posedge ref_clk);
        run_rs485 <= 1'b1;
        pick(4'h0);
        chk(run_cmd, 1);
        rd(8'h18, 32'h100000AB);
        chk(irq, 0);
        rd(8'h10, 32'h4);
        wr(8'h14, 32'h7);
        chk(irq, 1);
        wr(8'h10, 32'h4);
        chk(irq, 0);
        wr(8'h0C, 32'h00A);
        @(posedge ref_clk);
        motor_load_pct <= 8'h96;
        wt(0, 9, 13);
        chk(irq, 1);
        rd(8'h10, 32'h1);
        @(posedge ref_clk);
        motor_load_pct <= 8'h00;
        wr(8'h00, 32'h16);
        wr(8'h10, 32'h7);
        chk({motor_ol_trip, irq}, 0);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            out_freq <= (k == 2) ? 16'h0000 : 16'h0064;
            drive_load_pct <= dl[k];
            wt(1, dlo[k], dhi[k]);
            rd(8'h10, 32'h2);
            @(posedge ref_clk);
            drive_load_pct <= 8'h00;
            wr(8'h00, 32'h16);
            wr(8'h10, 32'h7);
            chk(drive_ol_trip, 0);
        end
        wr(8'h1C, 32'h100E0C00);
        pick(4'h1);
        chk(preset_active, 0);
        wr(8'h1C, 32'h100E0C0A);
        pick(4'h1);
        chk(preset_active, 1);
        complete_run();
    end
endmodule : pss_selector_tb_top
`default_nettype wire
